/* verilog/rmc_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 25 MHz system clock
// Notes:   included by bare name
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH

// ==========================================================
// register offsets
`define RMC_ADDR_CYCLE_GUARD      8'h14
`define RMC_ADDR_PREDIV_LOW       8'h15
`define RMC_ADDR_TRIG_AVG_HIGH    8'h16
`define RMC_ADDR_PORT_WARMUP_PIN  8'h17
`define RMC_ADDR_TIMEMEAS_A       8'h18
`define RMC_ADDR_TIMEMEAS_B       8'h19
`define RMC_ADDR_OLF_FREQ         8'h30
`define RMC_ADDR_RESULT_LOW       8'h31
`define RMC_ADDR_RESULT_HIGH      8'h32
`define RMC_ADDR_STATUS           8'h33

// ==========================================================
// implemented-bit masks
`define RMC_MASK_CYCLE_GUARD      8'h87
`define RMC_MASK_PREDIV_LOW       8'hff
`define RMC_MASK_TRIG_AVG_HIGH    8'h7f
`define RMC_MASK_PORT_WARMUP_PIN  8'hf7
`define RMC_MASK_TIMEMEAS_A       8'h3f
`define RMC_MASK_TIMEMEAS_B       8'hfc
`define RMC_MASK_OLF_FREQ         8'h03

// ==========================================================
// reset values
`define RMC_RST_CYCLE_GUARD       8'h07
`define RMC_RST_PREDIV_LOW        8'h00
`define RMC_RST_TRIG_AVG_HIGH     8'h50
`define RMC_RST_PORT_WARMUP_PIN   8'h00
`define RMC_RST_TIMEMEAS_A        8'h33
`define RMC_RST_TIMEMEAS_B        8'h04
`define RMC_RST_OLF_FREQ          8'h00

// ==========================================================
// field positions
`define RMC_CYCLE_SEL_BIT         7
`define RMC_TRIM_MSB              2
`define RMC_TRIG_SRC_MSB          6
`define RMC_TRIG_SRC_LSB          4
`define RMC_AVG_MSB               3
`define RMC_AVG_LSB               2
`define RMC_PREDIV_HIGH_MSB       1
`define RMC_PORT_SENSOR_BIT       7
`define RMC_PORT_REF_BIT          6
`define RMC_PORT_INT_SENSOR_BIT   5
`define RMC_PORT_INT_REFRES_BIT   4
`define RMC_WARMUP_BIT            2
`define RMC_PIN_SEL_MSB           1

// ==========================================================
// timing: clock rate, oscillator periods and cycle times in ns
`define RMC_CLK_MHZ               25
`define RMC_OLF_NS_10K            100000
`define RMC_OLF_NS_50K            20000
`define RMC_OLF_NS_100K           10000
`define RMC_OLF_NS_200K           5000
`define RMC_CYC0_NS_10K           100000
`define RMC_CYC1_NS_10K           200000
`define RMC_CYC0_NS_50K           20000
`define RMC_CYC1_NS_50K           40000
`define RMC_CYC0_NS_100K          10000
`define RMC_CYC1_NS_100K          20000
`define RMC_CYC0_NS_200K          20000
`define RMC_CYC1_NS_200K          40000
`define RMC_WARMUP_SHORT          5'h02
`define RMC_WARMUP_LONG           5'h08

`endif

/* verilog/rmc_pkg.sv */
// Purpose: shared types of the temperature measurement control
// Assumes: nothing
// Notes:   constants live in rmc_defines.svh
package rmc_pkg;

    // ==========================================================
    // sequencer states, gray along idle-wait-warm-measure-done
    typedef enum logic [2:0] {
        RMC_IDLE = 3'h0,
        RMC_WAIT = 3'h1,
        RMC_WARM = 3'h3,
        RMC_MEAS = 3'h2,
        RMC_DONE = 3'h6
    } rmc_state_t;

    // ==========================================================
    // trigger source codes
    typedef enum logic [2:0] {
        RMC_SRC_OFF      = 3'h0,
        RMC_SRC_TIMER    = 3'h1,
        RMC_SRC_PIN      = 3'h3,
        RMC_SRC_CDC_ASYN = 3'h5,
        RMC_SRC_CDC_SYN  = 3'h6
    } rmc_src_t;

    // ==========================================================
    // oscillator frequency
    typedef enum logic [1:0] {
        RMC_OLF_10K  = 2'h0,
        RMC_OLF_50K  = 2'h1,
        RMC_OLF_100K = 2'h2,
        RMC_OLF_200K = 2'h3
    } rmc_olf_t;

endpackage

/* verilog/rmc_prediv_if.sv */
// Purpose: link between sequencer and trigger pre-divider
// Assumes: single clock domain
// Notes:   pass is combinational from trig
`timescale 1ns/1ps
interface rmc_prediv_if;
    logic [9:0] factor;
    logic       trig;
    logic       hold;
    logic       pass;
    modport ctrl (output factor, output trig, output hold, input pass);
    modport div  (input factor, input trig, input hold, output pass);
endinterface

/* verilog/rmc_prediv.sv */
// Purpose: passes every nth trigger
// Assumes: reset already synchronised
// Notes:   factor 0 and 1 pass every trigger
`timescale 1ns/1ps
module rmc_prediv (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    // divider link
    rmc_prediv_if.div  pd
);
    logic [9:0] cnt_reg;
    logic       last;

    // ==========================================================
    // divider
    assign last    = (pd.factor <= 10'h001) || (cnt_reg == (pd.factor - 10'h001));
    assign pd.pass = pd.trig & last;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 10'h000;
        end else if (pd.hold) begin
            cnt_reg <= 10'h000;
        end else if (pd.trig) begin
            cnt_reg <= last ? 10'h000 : cnt_reg + 10'h001;
        end
    end
endmodule

/* verilog/rmc_top.sv */
// Purpose: temperature (resistance) conversion control and configuration
// Assumes: 25 MHz clk_i, oscillator derived as a divided enable pulse
// Notes on behaviour
// - cycle select bit 7 gives 100 or 200 us at 10 kHz oscillator.
// - cycle time follows oscillator: 50k 20/40, 100k 10/20, 200k 20/40 us.
// - ten-bit pre-divider passes every nth trigger, 0 and 1 pass all.
// - pre-divider sets capacitance to temperature conversion ratio.
// - timer source divides oscillator clock by the same pre-divider.
// - trigger source bits 6:4: off, timer, pin, cdc async, cdc sync.
// - codes 5 and 6 start on end of capacitance conversion.
// - opcode start works while idle (ignored while busy), any trigger source.
// - averaging bits 3:2 give 1, 4, 8 or 16 samples.
// - bit 6 enables reference port, bit 7 the sensor port.
// - bit 5 enables the internal aluminium sensor port.
// - bit 4 enables the internal reference resistor port.
// - warm-up bit 2 selects 2 or 8 warm-up cycles.
// - warm-up cycles run first and never enter the result.
// - pin select bits 1:0 pick which gp pin starts conversions.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "rmc_defines.svh"
module rmc_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // start sources
    input  wire logic        cdc_done_i,
    input  wire logic        opcode_start_i,
    input  wire logic [3:0]  gp_pin_i,
    // front end
    input  wire logic [15:0] sample_i,
    output logic             temp_reference_port_en_o,
    output logic             temp_sensor_port_en_o,
    output logic             internal_sensor_port_enable_o,
    output logic             internal_refres_port_enable_o,
    output logic      [2:0]  guard_amp_current_trim_o,
    output logic      [7:0]  timemeas_a_o,
    output logic      [7:0]  timemeas_b_o,
    // status
    output logic             cycle_strobe_o,
    output logic             warmup_o,
    output logic             busy_o,
    output logic      [15:0] result_o,
    output logic             result_valid_o
);
    // ==========================================================
    // reset release
    logic       rst_s1_reg;
    logic       rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ==========================================================
    // registers
    logic [7:0] cyc_reg;
    logic [7:0] pdl_reg;
    logic [7:0] trg_reg;
    logic [7:0] prt_reg;
    logic [7:0] tma_reg;
    logic [7:0] tmb_reg;
    logic [7:0] olf_reg;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cyc_reg <= `RMC_RST_CYCLE_GUARD;
            pdl_reg <= `RMC_RST_PREDIV_LOW;
            trg_reg <= `RMC_RST_TRIG_AVG_HIGH;
            prt_reg <= `RMC_RST_PORT_WARMUP_PIN;
            tma_reg <= `RMC_RST_TIMEMEAS_A;
            tmb_reg <= `RMC_RST_TIMEMEAS_B;
            olf_reg <= `RMC_RST_OLF_FREQ;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `RMC_ADDR_CYCLE_GUARD:     cyc_reg <= reg_wdata_i & `RMC_MASK_CYCLE_GUARD;
                `RMC_ADDR_PREDIV_LOW:      pdl_reg <= reg_wdata_i & `RMC_MASK_PREDIV_LOW;
                `RMC_ADDR_TRIG_AVG_HIGH:   trg_reg <= reg_wdata_i & `RMC_MASK_TRIG_AVG_HIGH;
                `RMC_ADDR_PORT_WARMUP_PIN: prt_reg <= reg_wdata_i & `RMC_MASK_PORT_WARMUP_PIN;
                `RMC_ADDR_TIMEMEAS_A:      tma_reg <= reg_wdata_i & `RMC_MASK_TIMEMEAS_A;
                `RMC_ADDR_TIMEMEAS_B:      tmb_reg <= reg_wdata_i & `RMC_MASK_TIMEMEAS_B;
                `RMC_ADDR_OLF_FREQ:        olf_reg <= reg_wdata_i & `RMC_MASK_OLF_FREQ;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // field decode
    logic              temp_cycle_select;
    logic [9:0]        temp_trigger_predivider;
    rmc_pkg::rmc_src_t temp_trigger_source;
    logic [1:0]        temp_average_depth;
    logic              warmup_long;
    logic [1:0]        temp_start_pin_select;
    rmc_pkg::rmc_olf_t olf_sel;

    assign temp_cycle_select       = cyc_reg[`RMC_CYCLE_SEL_BIT];
    assign temp_trigger_predivider = {trg_reg[`RMC_PREDIV_HIGH_MSB:0], pdl_reg};
    assign temp_trigger_source     =
        rmc_pkg::rmc_src_t'(trg_reg[`RMC_TRIG_SRC_MSB:`RMC_TRIG_SRC_LSB]);
    assign temp_average_depth      = trg_reg[`RMC_AVG_MSB:`RMC_AVG_LSB];
    assign warmup_long             = prt_reg[`RMC_WARMUP_BIT];
    assign temp_start_pin_select   = prt_reg[`RMC_PIN_SEL_MSB:0];
    assign olf_sel                 = rmc_pkg::rmc_olf_t'(olf_reg[1:0]);

    // ==========================================================
    // oscillator enable pulse
    localparam int OLF_CLKS_10K  = `RMC_OLF_NS_10K * `RMC_CLK_MHZ / 1000;
    localparam int OLF_CLKS_50K  = `RMC_OLF_NS_50K * `RMC_CLK_MHZ / 1000;
    localparam int OLF_CLKS_100K = `RMC_OLF_NS_100K * `RMC_CLK_MHZ / 1000;
    localparam int OLF_CLKS_200K = `RMC_OLF_NS_200K * `RMC_CLK_MHZ / 1000;

    logic [11:0] olf_cnt_reg;
    logic [11:0] olf_top;
    logic        olf_tick;

    always_comb begin
        case (olf_sel)
            rmc_pkg::RMC_OLF_10K:  olf_top = 12'(OLF_CLKS_10K - 1);
            rmc_pkg::RMC_OLF_50K:  olf_top = 12'(OLF_CLKS_50K - 1);
            rmc_pkg::RMC_OLF_100K: olf_top = 12'(OLF_CLKS_100K - 1);
            default:               olf_top = 12'(OLF_CLKS_200K - 1);
        endcase
    end

    assign olf_tick = (olf_cnt_reg >= olf_top);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            olf_cnt_reg <= 12'h000;
        end else begin
            olf_cnt_reg <= olf_tick ? 12'h000 : olf_cnt_reg + 12'h001;
        end
    end

    // ==========================================================
    // cycle length in oscillator periods
    localparam int C0_10K  = `RMC_CYC0_NS_10K / `RMC_OLF_NS_10K;
    localparam int C1_10K  = `RMC_CYC1_NS_10K / `RMC_OLF_NS_10K;
    localparam int C0_50K  = `RMC_CYC0_NS_50K / `RMC_OLF_NS_50K;
    localparam int C1_50K  = `RMC_CYC1_NS_50K / `RMC_OLF_NS_50K;
    localparam int C0_100K = `RMC_CYC0_NS_100K / `RMC_OLF_NS_100K;
    localparam int C1_100K = `RMC_CYC1_NS_100K / `RMC_OLF_NS_100K;
    localparam int C0_200K = `RMC_CYC0_NS_200K / `RMC_OLF_NS_200K;
    localparam int C1_200K = `RMC_CYC1_NS_200K / `RMC_OLF_NS_200K;

    logic [3:0] cyc_ticks;

    always_comb begin
        case (olf_sel)
            rmc_pkg::RMC_OLF_10K:  cyc_ticks = 4'(temp_cycle_select ? C1_10K : C0_10K);
            rmc_pkg::RMC_OLF_50K:  cyc_ticks = 4'(temp_cycle_select ? C1_50K : C0_50K);
            rmc_pkg::RMC_OLF_100K: cyc_ticks = 4'(temp_cycle_select ? C1_100K : C0_100K);
            default:               cyc_ticks = 4'(temp_cycle_select ? C1_200K : C0_200K);
        endcase
    end

    // ==========================================================
    // start pin synchronisers
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic [3:0] pin_s3_reg;
    logic [3:0] pin_lvl_reg;
    logic [3:0] pin_prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_reg[gi]   <= 1'b0;
                    pin_s2_reg[gi]   <= 1'b0;
                    pin_s3_reg[gi]   <= 1'b0;
                    pin_lvl_reg[gi]  <= 1'b0;
                    pin_prev_reg[gi] <= 1'b0;
                end else begin
                    pin_s1_reg[gi]   <= gp_pin_i[gi];
                    pin_s2_reg[gi]   <= pin_s1_reg[gi];
                    pin_s3_reg[gi]   <= pin_s2_reg[gi];
                    pin_prev_reg[gi] <= pin_lvl_reg[gi];
                    if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
                        pin_lvl_reg[gi] <= pin_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    logic pin_rise;
    assign pin_rise = pin_lvl_reg[temp_start_pin_select]
                    & ~pin_prev_reg[temp_start_pin_select];

    // ==========================================================
    // trigger source and pre-divider
    rmc_prediv_if pd ();
    logic src_trig;

    always_comb begin
        case (temp_trigger_source)
            rmc_pkg::RMC_SRC_TIMER:    src_trig = olf_tick;
            rmc_pkg::RMC_SRC_PIN:      src_trig = pin_rise;
            rmc_pkg::RMC_SRC_CDC_ASYN: src_trig = cdc_done_i;
            rmc_pkg::RMC_SRC_CDC_SYN:  src_trig = cdc_done_i;
            default:                   src_trig = 1'b0;
        endcase
    end

    assign pd.factor = temp_trigger_predivider;
    assign pd.trig   = src_trig;
    assign pd.hold   = (temp_trigger_source == rmc_pkg::RMC_SRC_OFF);

    rmc_prediv u_prediv (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .pd      (pd)
    );

    // ==========================================================
    // sequencer
    rmc_pkg::rmc_state_t state_reg;
    rmc_pkg::rmc_state_t state_next;
    logic [3:0]  tick_cnt_reg;
    logic [4:0]  smp_cnt_reg;
    logic [19:0] acc_reg;
    logic        cycle_end;
    logic        start_req;
    logic        sync_mode;
    logic [4:0]  warm_total;
    logic [4:0]  avg_total;

    assign start_req  = opcode_start_i | pd.pass;
    assign sync_mode  = (temp_trigger_source == rmc_pkg::RMC_SRC_CDC_SYN) & ~opcode_start_i;
    assign warm_total = warmup_long ? `RMC_WARMUP_LONG : `RMC_WARMUP_SHORT;
    assign avg_total  = (temp_average_depth == 2'h0) ? 5'h01 :
                        (5'h02 << temp_average_depth);
    assign cycle_end  = olf_tick && (tick_cnt_reg + 4'h1 >= cyc_ticks);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rmc_pkg::RMC_IDLE: begin
                if (start_req) begin
                    state_next = sync_mode ? rmc_pkg::RMC_WAIT : rmc_pkg::RMC_WARM;
                end
            end
            rmc_pkg::RMC_WAIT: begin
                if (olf_tick) begin
                    state_next = rmc_pkg::RMC_WARM;
                end
            end
            rmc_pkg::RMC_WARM: begin
                if (cycle_end && smp_cnt_reg + 5'h01 >= warm_total) begin
                    state_next = rmc_pkg::RMC_MEAS;
                end
            end
            rmc_pkg::RMC_MEAS: begin
                if (cycle_end && smp_cnt_reg + 5'h01 >= avg_total) begin
                    state_next = rmc_pkg::RMC_DONE;
                end
            end
            rmc_pkg::RMC_DONE: state_next = rmc_pkg::RMC_IDLE;
            default:           state_next = rmc_pkg::RMC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rmc_pkg::RMC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // cycle timer and sample counter, frozen while idle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 4'h0;
            smp_cnt_reg  <= 5'h00;
        end else if (state_reg != state_next) begin
            tick_cnt_reg <= 4'h0;
            smp_cnt_reg  <= 5'h00;
        end else if (cycle_end && (state_reg == rmc_pkg::RMC_WARM
                                   || state_reg == rmc_pkg::RMC_MEAS)) begin
            tick_cnt_reg <= 4'h0;
            smp_cnt_reg  <= smp_cnt_reg + 5'h01;
        end else if (olf_tick && state_reg != rmc_pkg::RMC_IDLE) begin
            tick_cnt_reg <= tick_cnt_reg + 4'h1;
        end
    end

    // accumulator takes only measuring cycles
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 20'h00000;
        end else if (state_reg == rmc_pkg::RMC_IDLE) begin
            acc_reg <= 20'h00000;
        end else if (cycle_end && state_reg == rmc_pkg::RMC_MEAS) begin
            acc_reg <= acc_reg + {4'h0, sample_i};
        end
    end

    // result and strobes
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_o       <= 16'h0000;
            result_valid_o <= 1'b0;
            cycle_strobe_o <= 1'b0;
        end else begin
            result_valid_o <= (state_reg == rmc_pkg::RMC_DONE);
            cycle_strobe_o <= cycle_end && (state_reg == rmc_pkg::RMC_WARM
                                            || state_reg == rmc_pkg::RMC_MEAS);
            if (state_reg == rmc_pkg::RMC_DONE) begin
                result_o <= 16'(acc_reg >> ((temp_average_depth == 2'h0) ? 3'h0 :
                                            3'(temp_average_depth) + 3'h1));
            end
        end
    end

    // ==========================================================
    // port enables and status outputs
    logic active;
    assign active = (state_reg == rmc_pkg::RMC_WARM) || (state_reg == rmc_pkg::RMC_MEAS);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            temp_reference_port_en_o      <= 1'b0;
            temp_sensor_port_en_o         <= 1'b0;
            internal_sensor_port_enable_o <= 1'b0;
            internal_refres_port_enable_o <= 1'b0;
            warmup_o                      <= 1'b0;
            busy_o                        <= 1'b0;
        end else begin
            temp_reference_port_en_o      <= active & prt_reg[`RMC_PORT_REF_BIT];
            temp_sensor_port_en_o         <= active & prt_reg[`RMC_PORT_SENSOR_BIT];
            internal_sensor_port_enable_o <= active & prt_reg[`RMC_PORT_INT_SENSOR_BIT];
            internal_refres_port_enable_o <= active & prt_reg[`RMC_PORT_INT_REFRES_BIT];
            warmup_o                      <= (state_next == rmc_pkg::RMC_WARM);
            busy_o                        <= (state_next != rmc_pkg::RMC_IDLE);
        end
    end

    assign guard_amp_current_trim_o = cyc_reg[`RMC_TRIM_MSB:0];
    assign timemeas_a_o             = tma_reg;
    assign timemeas_b_o             = tmb_reg;

    // ==========================================================
    // read port
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `RMC_ADDR_CYCLE_GUARD:     reg_rdata_o <= cyc_reg;
                `RMC_ADDR_PREDIV_LOW:      reg_rdata_o <= pdl_reg;
                `RMC_ADDR_TRIG_AVG_HIGH:   reg_rdata_o <= trg_reg;
                `RMC_ADDR_PORT_WARMUP_PIN: reg_rdata_o <= prt_reg;
                `RMC_ADDR_TIMEMEAS_A:      reg_rdata_o <= tma_reg;
                `RMC_ADDR_TIMEMEAS_B:      reg_rdata_o <= tmb_reg;
                `RMC_ADDR_OLF_FREQ:        reg_rdata_o <= olf_reg;
                `RMC_ADDR_RESULT_LOW:      reg_rdata_o <= result_o[7:0];
                `RMC_ADDR_RESULT_HIGH:     reg_rdata_o <= result_o[15:8];
                `RMC_ADDR_STATUS:          reg_rdata_o <= {5'h00, state_reg};
                default:                   reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule

/* verification/rmc_cap_model.sv */
// Purpose: capacitance side and sensor front end of rmc_top
// Assumes: shares the system clock
// Notes:   warm-up samples are poisoned so a leak shows
`timescale 1ns/1ps
module rmc_cap_model (
    input  wire logic        clk_i, run_i, busy_i, warm_i,
    output logic             cdc_done_o,
    output logic      [15:0] sample_o
);
    int gap = 0;
    // ==========================================================
    // end-of-conversion pulse after 40 idle clocks
    always @(posedge clk_i) begin
        gap <= (run_i && !busy_i && gap < 40) ? gap + 1 : 0;
        cdc_done_o <= run_i && !busy_i && gap == 39;
    end
    assign sample_o = warm_i ? 16'hffff : 16'h0100;
endmodule

/* verification/rmc_top_props.sv */
// Purpose: port assertions for rmc_top
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every rmc_top
`timescale 1ns/1ps
module rmc_top_props (
    input wire logic       clk_i, rst_n_i, reg_wr_i, opcode_start_i, busy_o, warmup_o,
    input wire logic       result_valid_o, temp_reference_port_en_o, temp_sensor_port_en_o,
    input wire logic       internal_sensor_port_enable_o, internal_refres_port_enable_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, timemeas_a_o, timemeas_b_o,
    input wire logic [2:0] guard_amp_current_trim_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence wr_at(a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // ==========================================================
    // conversion and register checks
    start_busy_a: assert property (opcode_start_i && !busy_o |=> busy_o && warmup_o)
        else $error("start ignored");
    ext_ports_a: assert property (temp_reference_port_en_o ||
        temp_sensor_port_en_o |-> busy_o) else $error("port on while idle");
    int_ports_a: assert property (internal_sensor_port_enable_o ||
        internal_refres_port_enable_o |-> busy_o) else $error("port on while idle");
    warm_busy_a: assert property (warmup_o |-> busy_o) else $error("stray warm-up");
    valid_once_a: assert property (result_valid_o |-> !warmup_o ##1 !result_valid_o)
        else $error("result valid too long");
    trim_write_a: assert property (wr_at(8'h14) |=>
        {5'h00, guard_amp_current_trim_o} == ($past(reg_wdata_i) & 8'h07)) else $error("trim");
    meas_a_write_a: assert property (wr_at(8'h18) |=>
        timemeas_a_o == ($past(reg_wdata_i) & 8'h3f)) else $error("fixed field a");
    meas_b_write_a: assert property (wr_at(8'h19) |=>
        timemeas_b_o == ($past(reg_wdata_i) & 8'hfc)) else $error("fixed field b");
endmodule
bind rmc_top rmc_top_props u_props (.*);

/* verification/tb_top.sv */
// Purpose: self-checking bench for rmc_top
// Assumes: oscillator code 3, one tick per 125 clocks
// Notes:   one task per scenario
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, run_i = 1'b0;
    logic        opcode_start_i = 1'b0, cdc_done_i, cycle_strobe_o, warmup_o, busy_o;
    logic        temp_reference_port_en_o, temp_sensor_port_en_o, result_valid_o;
    logic        internal_sensor_port_enable_o, internal_refres_port_enable_o;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [7:0]  timemeas_a_o, timemeas_b_o;
    logic [3:0]  gp_pin_i = 4'h0;
    logic [2:0]  guard_amp_current_trim_o;
    logic [15:0] sample_i, result_o;
    int          errors = 0, cmp_count = 0;
    rmc_top dut (.*);
    rmc_cap_model cap (.clk_i, .run_i, .busy_i(busy_o), .warm_i(warmup_o),
                       .cdc_done_o(cdc_done_i), .sample_o(sample_i));
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) if (cdc_done_i) gp_pin_i[0] <= ~gp_pin_i[0];
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [7:0] ad [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h30, 8'h40};
        logic [7:0] mk [8] = '{8'h87, 8'hff, 8'h7f, 8'hf7, 8'h3f, 8'hfc, 8'h03, 8'h00};
        for (int i = 0; i < 8; i++) begin
            wr(ad[i], 8'hff);
            reg_rd_i <= 1'b1;
            @(posedge clk_i);
            reg_rd_i <= 1'b0;
            @(posedge clk_i);
            chk(16'(reg_rdata_o), 16'(mk[i]));
        end
        chk(16'(guard_amp_current_trim_o), 16'h0007);
        wr(8'h18, 8'h33);
        wr(8'h19, 8'h04);
        wr(8'h30, 8'h03);
        @(posedge clk_i);
        chk({timemeas_a_o, timemeas_b_o}, 16'h3304);
        $display("registers done");
    endtask
    task automatic t_conv(input logic cy, input logic wm, input logic [1:0] av,
                          input logic [15:0] ns);
        int s = 0;
        int t0 = 0;
        int t1 = 0;
        logic [15:0] r;
        logic [3:0]  p = 4'h0;
        wr(8'h14, {cy, 7'h07});
        wr(8'h16, {4'h0, av, 2'h0});
        wr(8'h17, {cy, wm, ~cy, ~wm, 1'b0, wm, 2'h0});
        opcode_start_i <= 1'b1;
        @(posedge clk_i);
        opcode_start_i <= 1'b0;
        for (int n = 0; n < 20000 && (n < 2 || busy_o !== 1'b0); n++) begin
            @(posedge clk_i);
            if (cycle_strobe_o === 1'b1) begin
                t0 = t1;
                t1 = n;
                s++;
                p = {temp_sensor_port_en_o, temp_reference_port_en_o,
                     internal_sensor_port_enable_o, internal_refres_port_enable_o};
            end
            r = result_o;
        end
        chk(16'(s), ns);
        chk(16'(p), 16'({cy, wm, ~cy, ~wm}));
        chk(16'(t1 - t0), cy ? 16'h03e8 : 16'h01f4);
        chk(r, 16'h0100);
        $display("conversion done");
    endtask
    task automatic t_cdc(input logic [2:0] src, input logic [7:0] pd, input logic [15:0] e);
        logic [15:0] c = 16'h0000;
        logic [15:0] r = 16'h0000;
        wr(8'h15, pd);
        wr(8'h16, {1'b0, src, 4'h0});
        run_i <= 1'b1;
        for (int n = 0; n < 40000 && (c < 6 || run_i || busy_o !== 1'b0); n++) begin
            @(posedge clk_i);
            c += 16'(cdc_done_i === 1'b1);
            r += 16'(result_valid_o === 1'b1);
            if (c == 16'h0006)
                run_i <= 1'b0;
        end
        chk(r, e);
        $display("trigger done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        t_regs();
        t_conv(1'b1, 1'b1, 2'h1, 16'h000c);
        t_conv(1'b0, 1'b0, 2'h3, 16'h0012);
        t_cdc(3'h5, 8'h03, 16'h0002);
        t_cdc(3'h6, 8'h01, 16'h0006);
        t_cdc(3'h3, 8'h01, 16'h0003);
        t_cdc(3'h0, 8'h01, 16'h0000);
        give_verdict();
    end
    initial begin
        #3ms;
        errors++;
        give_verdict();
    end
endmodule
